// ==== logic/exec_pkg.sv ====
package exec_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] ADR_CMD     = 8'h00;
  localparam logic [7:0] ADR_OPERAND = 8'h04;
  localparam logic [7:0] ADR_ACC     = 8'h08;
  localparam logic [7:0] ADR_STATUS  = 8'h0c;
  localparam logic [7:0] ADR_PC      = 8'h10;
  localparam logic [7:0] ADR_WDT     = 8'h14;
  localparam logic [7:0] ADR_MEMDATA = 8'h18;
  localparam logic [7:0] ADR_STACK   = 8'h1c;

  // command codes written into the op field of the command register
  localparam logic [4:0] OP_NOP        = 5'h00;
  localparam logic [4:0] OP_ADC_A      = 5'h01;
  localparam logic [4:0] OP_ADC_M      = 5'h02;
  localparam logic [4:0] OP_ADD_A      = 5'h03;
  localparam logic [4:0] OP_ADD_X      = 5'h04;
  localparam logic [4:0] OP_ADD_M      = 5'h05;
  localparam logic [4:0] OP_AND_A      = 5'h06;
  localparam logic [4:0] OP_AND_X      = 5'h07;
  localparam logic [4:0] OP_AND_M      = 5'h08;
  localparam logic [4:0] OP_CALL       = 5'h09;
  localparam logic [4:0] OP_ZERO_BYTE  = 5'h0a;
  localparam logic [4:0] OP_ZERO_BIT   = 5'h0b;
  localparam logic [4:0] OP_WDT_SINGLE = 5'h0c;
  localparam logic [4:0] OP_WDT_PRE1   = 5'h0d;
  localparam logic [4:0] OP_WDT_PRE2   = 5'h0e;
  localparam logic [4:0] OP_INV_M      = 5'h0f;
  localparam logic [4:0] OP_INV_A      = 5'h10;
  localparam logic [4:0] OP_BCD_FIXUP  = 5'h11;
  localparam logic [4:0] OP_DEC_M      = 5'h12;
  localparam logic [4:0] OP_DEC_A      = 5'h13;
  localparam logic [4:0] OP_INC_M      = 5'h14;
  localparam logic [4:0] OP_INC_A      = 5'h15;
  localparam logic [4:0] OP_HALT       = 5'h16;
  localparam logic [4:0] OP_BRANCH     = 5'h17;

  // sizes and special addresses
  localparam int         DATA_WORDS  = 256;
  localparam int         STACK_DEPTH = 8;
  localparam logic [7:0] PC_LOW_ADDR = 8'h06;

  // one instruction cycle is four system clocks; counters load n-1
  localparam int         INSN_CLKS = 4;
  localparam logic [2:0] CYC_SHORT = 3'(INSN_CLKS - 1);
  localparam logic [2:0] CYC_LONG  = 3'(2 * INSN_CLKS - 1);

  // decimal adjust constants
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_FIX   = 5'h06;

  // watchdog prescaler default (clocks per watchdog count)
  localparam int WDT_DIV_DEFAULT = 256;

  // reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST  = 16'h0000;

  // status register bits above the six flag bits
  localparam int STAT_PRE1_BIT  = 6;
  localparam int STAT_PRE2_BIT  = 7;
  localparam int STAT_BUSY_BIT  = 8;
  localparam int STAT_HALT_BIT  = 9;

  // flags, bit 0 upward: carry, half carry, zero, overflow, power-down,
  // timeout
  typedef struct packed {
    logic to;
    logic pdn;
    logic sov;
    logic z;
    logic hc;
    logic c;
  } flags_s;

  localparam flags_s FLAGS_RST = 6'h00;

  // low byte of the command register
  typedef struct packed {
    logic [2:0] bit_sel;
    logic [4:0] op;
  } cmd_s;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_HALT} state_e;

endpackage : exec_pkg

// ==== logic/exec_core.sv ====
// How it works
// - sum_carry_to_acc: acc gets acc+mem+c; ov, z, ac, c updated
// - sum_carry_to_mem: mem gets acc+mem+c; ov, z, ac, c updated
// - plain add of mem or immediate into acc; ov, z, ac, c updated
// - sum_to_mem: mem gets acc+mem, acc kept; ov, z, ac, c updated
// - conjunction into acc with mem or immediate; only z updated
// - bitwise_conj_to_mem writes acc and mem into mem; only z updated
// - call pushes pc+1, loads target, leaves flags alone
// - zero_byte writes zero into the byte, no flags
// - bit clear zeroes one bit, keeps others, no flags
// - watchdog_single_clear zeroes counter, timeout_flag and powerdown_flag
// - preclear pair clears only once both ran; one alone just records
// - invert_byte and invert_byte_to_acc complement the byte, update z
// - bcd_fixup low nibble plus six if above nine or half carry
// - bcd_fixup high nibble plus six and internal carry; only c changes
// - minus_one forms subtract one, update only z
// - plus_one forms add one, update only z
// - halt advances pc, stops, clears watchdog and timeout, sets pd flag
// - unconditional_branch loads pc with the encoded target
// - writing program_counter_low costs one more instruction cycle
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module exec_core #(
  parameter int WDT_DIV = exec_pkg::WDT_DIV_DEFAULT // clocks per wdt count
) (
  input  wire logic        mclk_i,    // system clock, 250 MHz
  input  wire logic        rst_n_i,   // synchronous reset, active low
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,  // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,  // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic      [31:0] wb_dat_o,  // wishbone read data
  output logic             wb_ack_o,  // wishbone acknowledge
  input  wire logic        wake_i,    // leaves power-down
  output logic             halted_o   // power-down in force
);

  exec_pkg::state_e state_q;
  exec_pkg::flags_s flags_q;
  exec_pkg::cmd_s   cmd_w;
  exec_pkg::cmd_s   last_cmd_q;

  logic [7:0]  acc_q;
  logic [15:0] operand_q;
  logic [15:0] pc_q;
  logic [7:0]  wdt_q;
  logic [7:0]  presc_q;
  logic [2:0]  cnt_q;
  logic [2:0]  sp_q;
  logic        pre1_q;
  logic        pre2_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  dmem [exec_pkg::DATA_WORDS];
  logic [15:0] stack_q [exec_pkg::STACK_DEPTH];

  logic        req;
  logic        wr;
  logic        go;
  logic        busy;
  logic [7:0]  addr_w;
  logic [7:0]  imm_w;
  logic [7:0]  mem_b;
  logic        carry_w;
  logic [7:0]  addsrc;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic        ovf;
  logic [4:0]  lo_adj;
  logic [4:0]  hi_adj;
  logic        fix_lo;
  logic        fix_hi;
  logic        nib_c;
  logic [7:0]  res;
  logic        wr_acc;
  logic        wr_mem;
  logic        upd_arith;
  logic        upd_z;
  logic        pclo_hit;
  logic        long_w;
  logic        wdt_clr;
  logic        tick;
  logic        wdt_ovf;
  logic [31:0] rd_mux;

  // bus decode; writes take effect on the edge that carries the ack
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr      = req & wb_we_i & ack_q;
  assign busy    = (state_q == exec_pkg::S_EXEC);
  assign cmd_w   = exec_pkg::cmd_s'(wb_dat_i[7:0]);
  // a command while busy or halted is dropped, the ack still comes
  assign go      = wr & wb_sel_i[0] & (wb_adr_i == exec_pkg::ADR_CMD) &
                   (state_q == exec_pkg::S_IDLE);
  assign addr_w  = operand_q[7:0];
  assign imm_w   = operand_q[15:8];
  assign carry_w = flags_q.c;
  // the program counter low byte shadows one data address
  assign pclo_hit = (addr_w == exec_pkg::PC_LOW_ADDR);
  assign mem_b    = pclo_hit ? pc_q[7:0] : dmem[addr_w];

  // adder shared by all add forms
  assign addsrc = (cmd_w.op == exec_pkg::OP_ADD_X) ? imm_w : mem_b;
  assign cin    = carry_w & ((cmd_w.op == exec_pkg::OP_ADC_A) |
                             (cmd_w.op == exec_pkg::OP_ADC_M));
  assign sum9   = {1'b0, acc_q} + {1'b0, addsrc} + {8'h00, cin};
  assign half5  = {1'b0, acc_q[3:0]} + {1'b0, addsrc[3:0]} + {4'h0, cin};
  assign ovf    = (acc_q[7] == addsrc[7]) && (sum9[7] != acc_q[7]);

  // decimal adjust: internal carry only when the low fix was not caused
  // by a half carry, so a pending half carry never counts twice
  assign fix_lo = ({1'b0, acc_q[3:0]} > exec_pkg::BCD_LIMIT) | flags_q.hc;
  assign lo_adj = fix_lo ? {1'b0, acc_q[3:0]} + exec_pkg::BCD_FIX
                         : {1'b0, acc_q[3:0]};
  assign nib_c  = fix_lo & ~flags_q.hc;
  assign hi_adj = {1'b0, acc_q[7:4]} + {4'h0, nib_c};
  assign fix_hi = (hi_adj > exec_pkg::BCD_LIMIT) | flags_q.c;

  // result select for the instruction being issued
  always_comb begin
    res       = sum9[7:0];
    wr_acc    = 1'b0;
    wr_mem    = 1'b0;
    upd_arith = 1'b0;
    upd_z     = 1'b0;
    case (cmd_w.op)
      exec_pkg::OP_ADC_A, exec_pkg::OP_ADD_A, exec_pkg::OP_ADD_X: begin
        wr_acc    = 1'b1;
        upd_arith = 1'b1;
      end
      exec_pkg::OP_ADC_M, exec_pkg::OP_ADD_M: begin
        wr_mem    = 1'b1;
        upd_arith = 1'b1;
      end
      exec_pkg::OP_AND_A, exec_pkg::OP_AND_X: begin
        res    = acc_q & addsrc_and(cmd_w.op, imm_w, mem_b);
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      exec_pkg::OP_AND_M: begin
        res    = acc_q & mem_b;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      exec_pkg::OP_ZERO_BYTE: begin
        res    = 8'h00;
        wr_mem = 1'b1;
      end
      exec_pkg::OP_ZERO_BIT: begin
        res    = mem_b & ~(8'h01 << cmd_w.bit_sel);
        wr_mem = 1'b1;
      end
      exec_pkg::OP_INV_M, exec_pkg::OP_INV_A: begin
        res    = ~mem_b;
        wr_mem = (cmd_w.op == exec_pkg::OP_INV_M);
        wr_acc = (cmd_w.op == exec_pkg::OP_INV_A);
        upd_z  = 1'b1;
      end
      exec_pkg::OP_BCD_FIXUP: begin
        res    = {fix_hi ? 4'(hi_adj + exec_pkg::BCD_FIX)
                         : hi_adj[3:0], lo_adj[3:0]};
        wr_mem = 1'b1;
      end
      exec_pkg::OP_DEC_M, exec_pkg::OP_DEC_A: begin
        res    = mem_b - 8'h01;
        wr_mem = (cmd_w.op == exec_pkg::OP_DEC_M);
        wr_acc = (cmd_w.op == exec_pkg::OP_DEC_A);
        upd_z  = 1'b1;
      end
      exec_pkg::OP_INC_M, exec_pkg::OP_INC_A: begin
        res    = mem_b + 8'h01;
        wr_mem = (cmd_w.op == exec_pkg::OP_INC_M);
        wr_acc = (cmd_w.op == exec_pkg::OP_INC_A);
        upd_z  = 1'b1;
      end
      default: begin
        res = sum9[7:0];
      end
    endcase
  end

  function automatic logic [7:0] addsrc_and(input logic [4:0] op,
                                            input logic [7:0] imm,
                                            input logic [7:0] mem);
    addsrc_and = (op == exec_pkg::OP_AND_X) ? imm : mem;
  endfunction : addsrc_and

  // branches and calls take two cycles, as does a write to the pc low byte
  assign long_w = (cmd_w.op == exec_pkg::OP_BRANCH) |
                  (cmd_w.op == exec_pkg::OP_CALL) |
                  (wr_mem & pclo_hit);

  // sequencer: idle, executing for whole instruction cycles, powered down
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= exec_pkg::S_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      case (state_q)
        exec_pkg::S_IDLE: begin
          if (go && cmd_w.op == exec_pkg::OP_HALT) begin
            state_q <= exec_pkg::S_HALT;
          end else if (go) begin
            state_q <= exec_pkg::S_EXEC;
            cnt_q   <= long_w ? exec_pkg::CYC_LONG : exec_pkg::CYC_SHORT;
          end
        end
        exec_pkg::S_EXEC: begin
          if (cnt_q == 3'h0) begin
            state_q <= exec_pkg::S_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        exec_pkg::S_HALT: begin
          if (wake_i) begin
            state_q <= exec_pkg::S_IDLE;
          end
        end
        default: begin
          state_q <= exec_pkg::S_IDLE;
        end
      endcase
    end
  end

  // accumulator
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      acc_q <= exec_pkg::ACC_RST;
    end else if (go && wr_acc) begin
      acc_q <= res;
    end else if (wr && wb_sel_i[0] && wb_adr_i == exec_pkg::ADR_ACC) begin
      acc_q <= wb_dat_i[7:0];
    end
  end

  // operand register and last command, both software visible
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      operand_q  <= 16'h0000;
      last_cmd_q <= 8'h00;
    end else begin
      if (wr && wb_adr_i == exec_pkg::ADR_OPERAND) begin
        if (wb_sel_i[0]) operand_q[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) operand_q[15:8] <= wb_dat_i[15:8];
      end
      if (go) last_cmd_q <= cmd_w;
    end
  end

  // data memory; the pc low byte address is never stored here
  always_ff @(posedge mclk_i) begin
    if (go && wr_mem && !pclo_hit) begin
      dmem[addr_w] <= res;
    end else if (wr && wb_sel_i[0] && !pclo_hit &&
                 wb_adr_i == exec_pkg::ADR_MEMDATA) begin
      dmem[addr_w] <= wb_dat_i[7:0];
    end
  end

  // program counter and return stack
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pc_q <= exec_pkg::PC_RST;
      sp_q <= 3'h0;
    end else if (go) begin
      if (cmd_w.op == exec_pkg::OP_BRANCH) begin
        pc_q <= operand_q;
      end else if (cmd_w.op == exec_pkg::OP_CALL) begin
        stack_q[sp_q] <= pc_q + 16'h0001;
        sp_q          <= sp_q + 3'h1;
        pc_q          <= operand_q;
      end else if (wr_mem && pclo_hit) begin
        pc_q <= {pc_q[15:8], res};
      end else begin
        pc_q <= pc_q + 16'h0001;
      end
    end else if (wr && wb_adr_i == exec_pkg::ADR_PC) begin
      if (wb_sel_i[0]) pc_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) pc_q[15:8] <= wb_dat_i[15:8];
    end else if (wr && wb_sel_i[0] && pclo_hit &&
                 wb_adr_i == exec_pkg::ADR_MEMDATA) begin
      pc_q[7:0] <= wb_dat_i[7:0];
    end
  end

  // watchdog clear requests, the preclear pair needs both halves
  assign wdt_clr = go && ((cmd_w.op == exec_pkg::OP_WDT_SINGLE) ||
                          (cmd_w.op == exec_pkg::OP_HALT) ||
                          (cmd_w.op == exec_pkg::OP_WDT_PRE1 && pre2_q) ||
                          (cmd_w.op == exec_pkg::OP_WDT_PRE2 && pre1_q));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end else if (wdt_clr) begin
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end else if (go && cmd_w.op == exec_pkg::OP_WDT_PRE1) begin
      pre1_q <= 1'b1;
    end else if (go && cmd_w.op == exec_pkg::OP_WDT_PRE2) begin
      pre2_q <= 1'b1;
    end
  end

  // watchdog prescaler and counter; a clear also restarts the prescaler
  assign tick    = (presc_q == 8'(WDT_DIV - 1));
  assign wdt_ovf = tick && (wdt_q == 8'hff);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || wdt_clr) begin
      presc_q <= 8'h00;
      wdt_q   <= 8'h00;
    end else begin
      presc_q <= tick ? 8'h00 : presc_q + 8'h01;
      if (tick) wdt_q <= wdt_q + 8'h01;
    end
  end

  // status flags; a timeout in the same cycle as a clear still lands
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flags_q <= exec_pkg::FLAGS_RST;
    end else begin
      if (go && upd_arith) begin
        flags_q.sov <= ovf;
        flags_q.z   <= (sum9[7:0] == 8'h00);
        flags_q.hc  <= half5[4];
        flags_q.c  <= sum9[8];
      end else if (go && upd_z) begin
        flags_q.z <= (res == 8'h00);
      end else if (go && cmd_w.op == exec_pkg::OP_BCD_FIXUP) begin
        flags_q.c <= fix_hi;
      end else if (wr && wb_sel_i[0] &&
                   wb_adr_i == exec_pkg::ADR_STATUS) begin
        flags_q.c  <= wb_dat_i[0];
        flags_q.hc  <= wb_dat_i[1];
        flags_q.z   <= wb_dat_i[2];
        flags_q.sov <= wb_dat_i[3];
      end
      if (wdt_clr) begin
        flags_q.pdn <= (cmd_w.op == exec_pkg::OP_HALT);
        flags_q.to  <= 1'b0;
      end
      if (wdt_ovf) flags_q.to <= 1'b1;
    end
  end

  // read mux; unmapped addresses read as zero and still ack
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      exec_pkg::ADR_CMD:     rd_mux[7:0]  = last_cmd_q;
      exec_pkg::ADR_OPERAND: rd_mux[15:0] = operand_q;
      exec_pkg::ADR_ACC:     rd_mux[7:0]  = acc_q;
      exec_pkg::ADR_STATUS: begin
        rd_mux[5:0]                    = flags_q;
        rd_mux[exec_pkg::STAT_PRE1_BIT] = pre1_q;
        rd_mux[exec_pkg::STAT_PRE2_BIT] = pre2_q;
        rd_mux[exec_pkg::STAT_BUSY_BIT] = busy;
        rd_mux[exec_pkg::STAT_HALT_BIT] = (state_q == exec_pkg::S_HALT);
      end
      exec_pkg::ADR_PC:      rd_mux[15:0] = pc_q;
      exec_pkg::ADR_WDT:     rd_mux[7:0]  = wdt_q;
      exec_pkg::ADR_MEMDATA: rd_mux[7:0]  = mem_b;
      exec_pkg::ADR_STACK:   rd_mux[18:0] = {sp_q, stack_q[sp_q - 3'h1]};
      default:               rd_mux       = 32'h0000_0000;
    endcase
  end

  // one wait state: ack in the cycle after the request, then dropped
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) dat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign halted_o = (state_q == exec_pkg::S_HALT);

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_short;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_long;
    busy [*8] ##1 !busy;
  endsequence

  property p_adc_acc;
    go && cmd_w.op == exec_pkg::OP_ADC_A |=>
      acc_q == 8'($past(acc_q) + $past(mem_b) + {7'h00, $past(carry_w)});
  endproperty
  a_adc_acc: assert property (p_adc_acc) else $error("adc acc wrong");

  property p_add_imm;
    go && cmd_w.op == exec_pkg::OP_ADD_X |=>
      acc_q == 8'($past(acc_q) + $past(imm_w)) &&
      flags_q.z == (acc_q == 8'h00);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add imm wrong");

  property p_and_flags;
    go && cmd_w.op == exec_pkg::OP_AND_A |=>
      flags_q.c == $past(carry_w) && $stable(flags_q.sov) &&
      flags_q.z == (acc_q == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags");

  property p_call;
    go && cmd_w.op == exec_pkg::OP_CALL |=>
      pc_q == $past(operand_q) && $stable(flags_q) &&
      stack_q[sp_q - 3'h1] == 16'($past(pc_q) + 16'h0001);
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_zero_byte;
    go && cmd_w.op == exec_pkg::OP_ZERO_BYTE && !pclo_hit |=>
      dmem[$past(addr_w)] == 8'h00 && $stable(flags_q);
  endproperty
  a_zero_byte: assert property (p_zero_byte) else $error("clear byte");

  property p_wdt_single;
    go && cmd_w.op == exec_pkg::OP_WDT_SINGLE |=>
      wdt_q == 8'h00 && !flags_q.pdn;
  endproperty
  a_wdt_single: assert property (p_wdt_single) else $error("wdt clr");

  property p_pre_alone;
    go && cmd_w.op == exec_pkg::OP_WDT_PRE1 && !pre2_q |=>
      pre1_q && $stable(flags_q.pdn);
  endproperty
  a_pre_alone: assert property (p_pre_alone) else $error("preclear");

  property p_inc_acc;
    go && cmd_w.op == exec_pkg::OP_INC_A |=>
      acc_q == 8'($past(mem_b) + 8'h01) && $stable(flags_q.c);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("inc acc wrong");

  property p_halt;
    go && cmd_w.op == exec_pkg::OP_HALT |=>
      halted_o && flags_q.pdn && pc_q == 16'($past(pc_q) + 16'h0001);
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");

  property p_cyc_short;
    go && !long_w && cmd_w.op != exec_pkg::OP_HALT |=> s_short;
  endproperty
  a_cyc_short: assert property (p_cyc_short) else $error("short cyc");

  property p_cyc_long;
    go && long_w |=> s_long;
  endproperty
  a_cyc_long: assert property (p_cyc_long) else $error("long cyc");

endmodule : exec_core

`default_nettype wire

// ==== tb/mcu_instruction_execution_subset_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module mcu_instruction_execution_subset_bench;
  logic        mclk_i  = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [3:0]  wb_sel  = 4'h0;
  logic [31:0] wb_dat  = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wake_i  = 1'b0;
  logic        halted_o;
  int          n_fail    = 0;
  int          tests_run = 0;
  // operand sets: acc, memory byte, immediate, flags {ovf,zero,half,carry}
  logic [7:0]  va[3] = '{8'h7f, 8'hff, 8'h99};
  logic [7:0]  vm[3] = '{8'h39, 8'hff, 8'h20};
  logic [7:0]  vx[3] = '{8'h80, 8'h0f, 8'h67};
  logic [3:0]  vf[3] = '{4'h1, 4'h0, 4'h3};

  // small divider: timeout after 4096 clocks, reached only by long waits
  exec_core #(.WDT_DIV(16)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wake_i(wake_i), .halted_o(halted_o));

  // system clock, 4 ns period
  always #2 mclk_i = ~mclk_i;

  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= 4'h3;
    wb_dat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      tally_and_finish;
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd

  // issue a command, count status polls that still show busy
  task automatic ex(input logic [4:0] op, input logic [2:0] bs,
                    output int nb);
    logic [31:0] q;
    nb = 0;
    wr(exec_pkg::ADR_CMD, {24'h0, bs, op});
    do begin
      rd(exec_pkg::ADR_STATUS, q);
      if (q[8] === 1'b1) nb++;
    end while (q[8] === 1'b1 && nb < 20);
    if (nb >= 20) begin
      n_fail++;
      tally_and_finish;
    end
  endtask : ex

  // reference results; bcd carry counts the internal nibble carry
  function automatic void model(input int o, input logic [7:0] a, m, x,
    input logic [2:0] bs, input logic [3:0] f,
    output logic [7:0] na, nm, output logic [3:0] nf);
    logic [8:0] s;
    logic [4:0] h, hi;
    logic [7:0] b, r;
    logic       cin, ac1;
    na = a;
    nm = m;
    nf = f;
    cin = (o == 1 || o == 2) ? f[0] : 1'b0;
    b = (o == 4) ? x : m;
    if (o <= 5) begin
      s = a + b + cin;
      h = a[3:0] + b[3:0] + cin;
      r = s[7:0];
      nf = {(a[7] == b[7]) && (r[7] != a[7]), r == 8'h00, h[4], s[8]};
      if (o == 2 || o == 5) nm = r; else na = r;
    end else if (o <= 8) begin
      r = a & ((o == 7) ? x : m);
      nf[2] = (r == 8'h00);
      if (o == 8) nm = r; else na = r;
    end else if (o == 10) nm = 8'h00;
    else if (o == 11) nm[bs] = 1'b0;
    else if (o == 17) begin
      h = {1'b0, a[3:0]};
      ac1 = 1'b0;
      if (h > 5'h09 || f[1]) begin
        h = h + 5'h06;
        ac1 = ~f[1];
      end
      hi = a[7:4] + ac1;
      if (hi > 5'h09 || f[0]) begin
        hi = hi + 5'h06;
        nf[0] = 1'b1;
      end
      nm = {hi[3:0], h[3:0]};
    end else begin
      r = (o == 15 || o == 16) ? ~m : (o < 20) ? m - 8'h01 : m + 8'h01;
      nf[2] = (r == 8'h00);
      if (o == 15 || o == 18 || o == 20) nm = r; else na = r;
    end
  endfunction : model

  initial begin
    logic [31:0] q;
    logic [7:0]  na, nm;
    logic [3:0]  nf;
    int          nb;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(exec_pkg::ADR_ACC, q);
    chk("acc_rst", q, 32'h0);
    rd(exec_pkg::ADR_STATUS, q);
    chk("status_rst", q, 32'h0);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    // every data command against each operand set
    for (int i = 0; i < 3; i++) begin
      for (int o = 1; o <= 21; o++) begin
        if (o == 9 || (o >= 12 && o <= 14)) continue;
        model(o, va[i], vm[i], vx[i], 3'(i + 3), vf[i], na, nm, nf);
        wr(exec_pkg::ADR_OPERAND, {16'h0, vx[i], 8'h20});
        wr(exec_pkg::ADR_MEMDATA, {24'h0, vm[i]});
        wr(exec_pkg::ADR_ACC, {24'h0, va[i]});
        wr(exec_pkg::ADR_STATUS, {28'h0, vf[i]});
        ex(5'(o), 3'(i + 3), nb);
        chk($sformatf("short %0d", o), nb <= 2, 1);
        rd(exec_pkg::ADR_ACC, q);
        chk($sformatf("acc %0d", o), q[7:0], na);
        rd(exec_pkg::ADR_MEMDATA, q);
        chk($sformatf("mem %0d", o), q[7:0], nm);
        rd(exec_pkg::ADR_STATUS, q);
        chk($sformatf("flg %0d", o), q[3:0], nf);
      end
    end
    $display("test data ops done");
    // call, branch and a clear aimed at the pc low byte take two cycles
    wr(exec_pkg::ADR_PC, 32'h0100);
    wr(exec_pkg::ADR_OPERAND, 32'h1234);
    wr(exec_pkg::ADR_STATUS, 32'h5);
    ex(exec_pkg::OP_CALL, 3'h0, nb);
    chk("call_long", nb >= 3, 1);
    rd(exec_pkg::ADR_PC, q);
    chk("call_pc", q[15:0], 16'h1234);
    rd(exec_pkg::ADR_STACK, q);
    chk("call_push", q[15:0], 16'h0101);
    chk("call_sp", q[18:16], 3'h1);
    rd(exec_pkg::ADR_STATUS, q);
    chk("call_flg", q[3:0], 4'h5);
    wr(exec_pkg::ADR_OPERAND, 32'h0abc);
    ex(exec_pkg::OP_BRANCH, 3'h0, nb);
    chk("br_long", nb >= 3, 1);
    rd(exec_pkg::ADR_PC, q);
    chk("br_pc", q[15:0], 16'h0abc);
    wr(exec_pkg::ADR_PC, 32'h0255);
    wr(exec_pkg::ADR_OPERAND, 32'h0006);
    ex(exec_pkg::OP_ZERO_BYTE, 3'h0, nb);
    chk("pcl_long", nb >= 3, 1);
    rd(exec_pkg::ADR_PC, q);
    chk("pcl_pc", q[15:0], 16'h0200);
    $display("test flow done");
    // power-down, wake, then the watchdog clears
    wr(exec_pkg::ADR_PC, 32'h0040);
    ex(exec_pkg::OP_HALT, 3'h0, nb);
    chk("halted", halted_o, 1);
    rd(exec_pkg::ADR_STATUS, q);
    chk("halt_flg", q[5:4], 2'b01);
    rd(exec_pkg::ADR_PC, q);
    chk("halt_pc", q[15:0], 16'h0041);
    rd(exec_pkg::ADR_WDT, q);
    chk("halt_wdt", q < 2, 1);
    wake_i <= 1'b1;
    @(posedge mclk_i);
    wake_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("woke", halted_o, 0);
    ex(exec_pkg::OP_WDT_PRE1, 3'h0, nb);
    ex(exec_pkg::OP_WDT_PRE1, 3'h0, nb);
    rd(exec_pkg::ADR_STATUS, q);
    chk("pre_one", q[7:4], 4'b0101);
    ex(exec_pkg::OP_WDT_PRE2, 3'h0, nb);
    rd(exec_pkg::ADR_STATUS, q);
    chk("pre_both", q[7:4], 4'b0000);
    ex(exec_pkg::OP_HALT, 3'h0, nb);
    wake_i <= 1'b1;
    @(posedge mclk_i);
    wake_i <= 1'b0;
    repeat (4200) @(posedge mclk_i);
    rd(exec_pkg::ADR_STATUS, q);
    chk("to_set", q[5:4], 2'b11);
    ex(exec_pkg::OP_WDT_SINGLE, 3'h0, nb);
    rd(exec_pkg::ADR_STATUS, q);
    chk("single_flg", q[5:4], 2'b00);
    rd(exec_pkg::ADR_WDT, q);
    chk("single_wdt", q < 2, 1);
    repeat (4200) @(posedge mclk_i);
    rd(exec_pkg::ADR_STATUS, q);
    chk("to_again", q[5:4], 2'b10);
    ex(exec_pkg::OP_HALT, 3'h0, nb);
    rd(exec_pkg::ADR_STATUS, q);
    chk("halt_to", q[5:4], 2'b01);
    $display("test watchdog done");
    tally_and_finish;
  end
endmodule : mcu_instruction_execution_subset_bench

`default_nettype wire
